// >>> verilog/mai_consts.vh
// Constants for the multidrop address interrogation block
// Functional notes
// R01: From wait-for-address the selector goes to exactly one of unselected, single, multi/broadcast or interrogation; the code stays in wait on F0/F1 hex.
// R02: After any reset or return-to-wait, Capture-IR loads the pattern with 01 in its two low bits.
// R03: An interrogation opcode 3A hex in the instruction register is copied to the address register at Update-IR.
// R04: While interrogating, each later Capture-IR loads the inverted slot address instead of the normal pattern.
// R05: Interrogation ones are driven weakly and zeros strongly so the shared line forms a wired-AND.
// R06: The inverted address shifts out least significant bit first, in step with the opcode shifting in.
// R07: Each driven bit is compared with the level seen on the shared line and a mismatch is a compare error.
// R08: A clean address shift releases the output and enters wait-for-reset at Update-IR.
// R09: A compare error stops the address shift, releases the output and enters wait-for-next-interrogation.
// R10: Wait-for-next-interrogation retries on the next Shift-IR if the last instruction was 3A hex.
// R11: Any other instruction during interrogation returns the selector to wait-for-address.
// R12: The test master repeats 3A hex scans until it reads all ones.
// R13: No bridge is given slot address zero.
// R14: Wait-for-reset is left only by test reset, five TMS-high clocks or the soft-reset command.
// R15: The line level for the compare is sampled on the same test clock edge that shifts the next bit.
`ifndef MAI_CONSTS_VH
`define MAI_CONSTS_VH
`define MAI_IR_W 8
`define MAI_ADDR_W 7
`define MAI_INTERROG_OP 8'h3a
`define MAI_CAPTURE_PAT 8'h01
`define MAI_SOFT_RESET_OP 8'hf0
`define MAI_RETURN_WAIT_OP 8'hf1
`define MAI_BCAST_OP 8'h3f
`define MAI_MCAST_BASE 8'h3b
`define MAI_MCAST_LAST 8'h3e
`define MAI_SYNC_W 5
`endif

// >>> verilog/mai_sync.v
// Two-flop synchronisers for the link inputs
`timescale 1ns/1ps
module mai_sync #(
	parameter W = 1
) (
	// Clock and reset
	input wire mclk,
	input wire rst_n,
	// Data
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1)
		begin : g_bit
			reg s1_r;
			reg s2_r;
			always @(posedge mclk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
				end
				else
				begin
					s1_r <= d[i];
					s2_r <= s1_r;
				end
			end
			assign q[i] = s2_r;
		end
	endgenerate
endmodule // mai_sync

// >>> verilog/mai_interrogate.v
// Backplane TAP tracking, selection and address interrogation
`timescale 1ns/1ps
`include "mai_consts.vh"
module mai_interrogate #(
	parameter ADDR_W = `MAI_ADDR_W,
	parameter [7:0] SOFT_RESET_OP = `MAI_SOFT_RESET_OP,
	parameter [7:0] RETURN_WAIT_OP = `MAI_RETURN_WAIT_OP
) (
	// Clock and reset
	input wire mclk,
	input wire rst_n,
	// Backplane test port
	input wire tck,
	input wire tms,
	input wire tdi,
	input wire trst_n,
	input wire tdo_line,
	output reg tdo_out_r,
	output reg tdo_oe_r,
	output reg tdo_weak_r,
	// Slot address pins
	input wire [ADDR_W-1:0] slot_addr,
	// Status
	output reg [6:0] sel_state_r,
	output reg [7:0] ir_r,
	output reg [7:0] addr_reg_r
);
	// ----------------------------------------
	// Selection and TAP states
	// ----------------------------------------
	localparam [6:0] S_WAIT = 7'h01, S_UNSEL = 7'h02, S_SINGLE = 7'h04, S_MULTI = 7'h08;
	localparam [6:0] S_INTG = 7'h10, S_WFNI = 7'h20, S_WFR = 7'h40;
	localparam [15:0] T_TLR = 16'h0001, T_RTI = 16'h0002, T_SDRS = 16'h0004, T_CDR = 16'h0008;
	localparam [15:0] T_SDR = 16'h0010, T_E1DR = 16'h0020, T_PDR = 16'h0040, T_E2DR = 16'h0080;
	localparam [15:0] T_UDR = 16'h0100, T_SIRS = 16'h0200, T_CIR = 16'h0400, T_SIR = 16'h0800;
	localparam [15:0] T_E1IR = 16'h1000, T_PIR = 16'h2000, T_E2IR = 16'h4000, T_UIR = 16'h8000;

	// ----------------------------------------
	// Input synchronisation and edges
	// ----------------------------------------
	wire [`MAI_SYNC_W+ADDR_W-1:0] sync_q;
	wire tck_s;
	wire tms_s;
	wire tdi_s;
	wire trst_n_s;
	wire line_s;
	wire [ADDR_W-1:0] slot_s;
	reg tck_d_r;
	wire rise;
	wire fall;

	mai_sync #(
		.W(`MAI_SYNC_W + ADDR_W)
	) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.d({slot_addr, tdo_line, trst_n, tdi, tms, tck}),
		.q(sync_q)
	);

	assign tck_s = sync_q[0];
	assign tms_s = sync_q[1];
	assign tdi_s = sync_q[2];
	assign trst_n_s = sync_q[3];
	assign line_s = sync_q[4];
	assign slot_s = sync_q[`MAI_SYNC_W+ADDR_W-1:`MAI_SYNC_W];
	assign rise = tck_s & ~tck_d_r;
	assign fall = ~tck_s & tck_d_r;

	// ----------------------------------------
	// TAP controller
	// ----------------------------------------
	reg [15:0] tap_r;
	reg [15:0] tap_nxt;

	always @*
	begin
		case (tap_r)
			T_TLR: tap_nxt = tms_s ? T_TLR : T_RTI;
			T_RTI: tap_nxt = tms_s ? T_SDRS : T_RTI;
			T_SDRS: tap_nxt = tms_s ? T_SIRS : T_CDR;
			T_CDR: tap_nxt = tms_s ? T_E1DR : T_SDR;
			T_SDR: tap_nxt = tms_s ? T_E1DR : T_SDR;
			T_E1DR: tap_nxt = tms_s ? T_UDR : T_PDR;
			T_PDR: tap_nxt = tms_s ? T_E2DR : T_PDR;
			T_E2DR: tap_nxt = tms_s ? T_UDR : T_SDR;
			T_UDR: tap_nxt = tms_s ? T_SDRS : T_RTI;
			T_SIRS: tap_nxt = tms_s ? T_TLR : T_CIR;
			T_CIR: tap_nxt = tms_s ? T_E1IR : T_SIR;
			T_SIR: tap_nxt = tms_s ? T_E1IR : T_SIR;
			T_E1IR: tap_nxt = tms_s ? T_UIR : T_PIR;
			T_PIR: tap_nxt = tms_s ? T_E2IR : T_PIR;
			T_E2IR: tap_nxt = tms_s ? T_UIR : T_SIR;
			T_UIR: tap_nxt = tms_s ? T_SDRS : T_RTI;
			default: tap_nxt = T_TLR;
		endcase
	end

	// ----------------------------------------
	// Shift path, selection and interrogation
	// ----------------------------------------
	reg [7:0] shreg_r;
	reg drv_r;
	reg done_r;
	reg [3:0] cnt_r;
	wire enter_uir;
	wire tap_reset;
	wire miss;

	assign enter_uir = rise & (tap_nxt == T_UIR);
	assign tap_reset = ~trst_n_s | (tap_r == T_TLR); // R14
	assign miss = line_s != tdo_out_r; // R07

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tck_d_r <= 1'b0;
			tap_r <= T_TLR;
			sel_state_r <= S_WAIT;
			ir_r <= `MAI_CAPTURE_PAT;
			addr_reg_r <= 8'h00;
			shreg_r <= 8'h00;
			drv_r <= 1'b0;
			done_r <= 1'b0;
			cnt_r <= 4'h0;
			tdo_out_r <= 1'b1;
			tdo_oe_r <= 1'b0;
			tdo_weak_r <= 1'b0;
		end
		else
		begin
			tck_d_r <= tck_s;
			if (!trst_n_s)
				tap_r <= T_TLR;
			else if (rise)
				tap_r <= tap_nxt;
			if (tap_reset)
			begin
				sel_state_r <= S_WAIT; // R14
				ir_r <= `MAI_CAPTURE_PAT;
				drv_r <= 1'b0;
				done_r <= 1'b0;
				tdo_oe_r <= 1'b0;
			end
			else if (rise && tap_r == T_CIR)
			begin
				cnt_r <= 4'h0;
				done_r <= 1'b0;
				if (sel_state_r == S_INTG)
				begin
					shreg_r <= {{(8-ADDR_W){1'b1}}, ~slot_s}; // R04
					drv_r <= 1'b1;
				end
				else
					shreg_r <= `MAI_CAPTURE_PAT; // R02
			end
			else if (rise && tap_r == T_SIR)
			begin
				shreg_r <= {tdi_s, shreg_r[7:1]}; // R06
				if (drv_r && tdo_oe_r && miss) // R15
				begin
					drv_r <= 1'b0; // R09
					tdo_oe_r <= 1'b0;
					sel_state_r <= S_WFNI;
				end
				else if (drv_r && tdo_oe_r)
				begin
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == ADDR_W - 1)
					begin
						done_r <= 1'b1;
						drv_r <= 1'b0;
					end
				end
				if (enter_uir)
					tdo_oe_r <= 1'b0;
			end
			else if (enter_uir)
			begin
				tdo_oe_r <= 1'b0;
				drv_r <= 1'b0;
				if (sel_state_r != S_WFR || shreg_r == SOFT_RESET_OP)
					ir_r <= shreg_r;
				if (shreg_r == SOFT_RESET_OP)
					sel_state_r <= S_WAIT; // R14
				else if (sel_state_r == S_WFR)
					sel_state_r <= S_WFR;
				else if (shreg_r == RETURN_WAIT_OP)
					sel_state_r <= S_WAIT; // R02
				else if (sel_state_r == S_WAIT)
				begin
					if (shreg_r == `MAI_INTERROG_OP)
					begin
						sel_state_r <= S_INTG; // R01
						addr_reg_r <= shreg_r; // R03
					end
					else if (shreg_r == {{(8-ADDR_W){1'b0}}, slot_s})
						sel_state_r <= S_SINGLE; // R01
					else if (shreg_r == `MAI_BCAST_OP ||
						(shreg_r >= `MAI_MCAST_BASE && shreg_r <= `MAI_MCAST_LAST))
						sel_state_r <= S_MULTI; // R01
					else
						sel_state_r <= S_UNSEL; // R01
				end
				else if (sel_state_r == S_INTG || sel_state_r == S_WFNI)
				begin
					if (shreg_r != `MAI_INTERROG_OP)
						sel_state_r <= S_WAIT; // R11
					else if (sel_state_r == S_INTG && done_r)
						sel_state_r <= S_WFR; // R08
					else
						sel_state_r <= S_INTG; // R10
				end
			end
			else if (fall)
			begin
				if (tap_r == T_SIR && drv_r)
				begin
					tdo_oe_r <= 1'b1;
					tdo_out_r <= shreg_r[0]; // R06
					tdo_weak_r <= shreg_r[0]; // R05
				end
				else if (tap_r == T_SIR && sel_state_r == S_SINGLE)
				begin
					tdo_oe_r <= 1'b1;
					tdo_out_r <= shreg_r[0];
					tdo_weak_r <= 1'b0;
				end
				else
				begin
					tdo_oe_r <= 1'b0;
					tdo_out_r <= 1'b1;
					tdo_weak_r <= 1'b0;
				end
			end
		end
	end
endmodule // mai_interrogate

// >>> sim/mai_interrogate_assertions.sv
// Checker for the interrogation block
`timescale 1ns/1ps
module mai_interrogate_assertions (
	// Clock and reset
	input wire mclk,
	input wire rst_n,
	// Outputs
	input wire tdo_out_r,
	input wire tdo_oe_r,
	input wire tdo_weak_r,
	input wire [6:0] sel_state_r,
	input wire [7:0] addr_reg_r
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_ONEHOT: assert property ($onehot(sel_state_r)) else $error("state not one-hot");
	AST_WEAK: assert property (sel_state_r[4] && tdo_oe_r && tdo_out_r |-> tdo_weak_r) else $error("one not weak");
	AST_STRONG: assert property (tdo_oe_r && !tdo_out_r |-> !tdo_weak_r) else $error("zero weak");
	AST_ENTER: assert property ($rose(sel_state_r[4]) && $past(sel_state_r[0]) |-> addr_reg_r == 8'h3a)
		else $error("address reg");
	AST_QUIET: assert property (sel_state_r[6] |-> !tdo_oe_r) else $error("drive when done");
	AST_ERR: assert property (sel_state_r[5] |-> !tdo_oe_r) else $error("drive after loss");
	AST_DONE: assert property ($fell(sel_state_r[6]) |-> sel_state_r[0]) else $error("left done");
	AST_EXIT: assert property ($fell(sel_state_r[4]) && !sel_state_r[6:5] |-> sel_state_r[0])
		else $error("bad exit");
endmodule // mai_interrogate_assertions
bind mai_interrogate mai_interrogate_assertions mai_chk (.mclk(mclk), .rst_n(rst_n), .tdo_out_r(tdo_out_r),
	.tdo_oe_r(tdo_oe_r), .tdo_weak_r(tdo_weak_r), .sel_state_r(sel_state_r), .addr_reg_r(addr_reg_r));

// >>> sim/mai_peer.sv
// Peer bridge on the shared test data wire
`timescale 1ns/1ps
module mai_peer (
	// Link
	input wire tck,
	input wire go,
	input wire [6:0] slot,
	// Pull-down of the wire
	output reg low
);
	reg [2:0] n;
	initial n = 3'h0;
	initial low = 1'b0;
	always @(negedge tck)
	begin
		low <= go && n < 3'h7 && slot[n];
		n <= go ? n + 3'h1 : 3'h0;
	end
endmodule // mai_peer

// >>> sim/testbench.sv
// Self-checking bench for the interrogation block
`timescale 1ns/1ps
module testbench;
	reg mclk, rst_n, tck, tms, tdi, trst_n, go, act;
	reg [6:0] slot, pslot;
	reg [7:0] rd, op;
	reg [8:0] e;
	wire out, oe, low, line;
	wire [6:0] st;
	wire [7:0] ir_v, ar;
	integer failures, comparisons, r, j, k, s;
	assign line = !(oe && !out) && !low;
	mai_interrogate mai_interrogate_inst (.mclk(mclk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
		.trst_n(trst_n), .tdo_line(line), .tdo_out_r(out), .tdo_oe_r(oe), .tdo_weak_r(),
		.slot_addr(slot), .sel_state_r(st), .ir_r(ir_v), .addr_reg_r(ar));
	mai_peer mai_peer_inst (.tck(tck), .go(go), .slot(pslot), .low(low));
	initial
	begin
		mclk = 0;
		forever #10 mclk = ~mclk;
	end
	task complete_run;
	begin
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	task cmp(input string nm, input [7:0] x, input [7:0] g);
	begin
		comparisons = comparisons + 1;
		if (x !== g)
		begin
			failures = failures + 1;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	end
	endtask
	task tk(input m, input d);
	begin
		tck = 0;
		tms = m;
		tdi = d;
		repeat (4) @(negedge mclk);
		tck = 1;
		repeat (4) @(negedge mclk);
	end
	endtask
	task ir(input [7:0] op, input p);
	begin
		tk(1, 0);
		tk(1, 0);
		tk(0, 0);
		tk(0, 0);
		go = p;
		for (k = 0; k < 8; k = k + 1)
		begin
			tk(k == 7, op[k]);
			rd = {line, rd[7:1]};
		end
		go = 0;
		tk(1, 0);
		tk(0, 0);
	end
	endtask
	function [8:0] model(input [6:0] a, input [6:0] b, input p, input on);
		integer i;
		reg w;
		begin
			model[8] = on;
			model[7] = 1'b1;
			for (i = 0; i < 7; i = i + 1)
			begin
				w = (!model[8] || !a[i]) && !(p && b[i]);
				if (model[8] && w !== !a[i])
					model[8] = 1'b0;
				model[i] = w;
			end
		end
	endfunction
	function [7:0] sel_exp(input [7:0] o, input [6:0] a);
		begin
			if (o == {1'b0, a})
				sel_exp = 8'h04;
			else if (o >= 8'h3b && o <= 8'h3f)
				sel_exp = 8'h08;
			else
				sel_exp = 8'h02;
		end
	endfunction
	initial
	begin
		#1000000;
		failures = failures + 1;
		complete_run;
	end
	initial
	begin
		failures = 0;
		comparisons = 0;
		rst_n = 0;
		tck = 0;
		tms = 1;
		tdi = 0;
		trst_n = 1;
		go = 0;
		slot = 7'h01;
		pslot = 7'h7f;
		s = $urandom(32'h1598);
		repeat (5) @(negedge mclk);
		rst_n = 1;
		repeat (8) @(negedge mclk);
		cmp("ir", 8'h01, ir_v);
		tk(0, 0);
		for (r = 0; r < 6; r = r + 1)
		begin
			ir(8'h3a, 0);
			cmp("addr", 8'h3a, ar);
			ir(8'h55, 0);
			cmp("state", 8'h01, {1'b0, st});
			ir(8'h3a, 0);
			cmp("state", 8'h10, {1'b0, st});
			act = 1;
			for (j = 0; j < 3; j = j + 1)
			begin
				ir(8'h3a, j == 0);
				e = model(slot, pslot, j == 0, act);
				act = act && !e[8];
				cmp("readout", e[7:0], rd);
				cmp("state", act ? 8'h10 : 8'h40, {1'b0, st});
			end
			ir(8'hf1, 0);
			cmp("state", 8'h40, {1'b0, st});
			case (r % 3)
				0: ir(8'hf0, 0);
				1: repeat (5) tk(1, 0);
				default:
				begin
					trst_n = 0;
					repeat (4) @(negedge mclk);
					trst_n = 1;
				end
			endcase
			tk(0, 0);
			cmp("state", 8'h01, {1'b0, st});
			case (r % 3)
				0: op = {1'b0, slot};
				1: op = 8'h3b + 8'($urandom_range(4, 0));
				default: op = 8'h80 + 8'($urandom_range(111, 0));
			endcase
			ir(op, 0);
			cmp("select", sel_exp(op, slot), {1'b0, st});
			ir(8'hf1, 0);
			cmp("capture", (r % 3 == 0) ? 8'h01 : 8'hff, rd);
			cmp("state", 8'h01, {1'b0, st});
			slot = $urandom_range(127, 1);
			if (slot >= 7'h3a && slot <= 7'h3f)
				slot = slot + 7'h08;
			pslot = $urandom_range(127, 1);
		end
		complete_run;
	end
endmodule // testbench
